// *** rtl/pfcs_pkg.sv ***
package pfcs_pkg;
  localparam int CLK_NS = 4;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // command sequence addresses and data
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 17'h0_5555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 17'h0_2AAA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_A = 8'hAA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_B = 8'h55;
  localparam logic [DATA_W-1:0] CODE_PROGRAM = 8'hA0;
  localparam logic [DATA_W-1:0] CODE_SETUP = 8'h80;
  localparam logic [DATA_W-1:0] CODE_ERASE = 8'h10;
  localparam logic [DATA_W-1:0] CODE_LOCKOUT = 8'h40;
  localparam logic [DATA_W-1:0] CODE_ID_ENTRY = 8'h90;
  localparam logic [DATA_W-1:0] CODE_ID_EXIT = 8'hF0;
  localparam int POLL_BIT = 7;
  localparam int ALT_BIT = 6;

  // step counts per command
  localparam logic [2:0] STEPS_PROGRAM = 3'h4;
  localparam logic [2:0] STEPS_SIX = 3'h6;
  localparam logic [2:0] STEPS_THREE = 3'h3;
  localparam logic [2:0] STEPS_ONE = 3'h1;

  // bus timing: glitch filter width is a least time, rounded up plus one cycle
  localparam int GLITCH_NS = 15;
  localparam int WE_LOW_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int ACCESS_NS = 120;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLOAT_NS = 30;
  localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 2;

  // completion limits: longest times, rounded down
  localparam longint ERASE_CYCLE_TIME_S = 10;
  localparam longint BYTE_PROGRAM_TIME_US = 50;
  localparam int unsigned ERASE_LIMIT_CYC =
    32'(ERASE_CYCLE_TIME_S * 1000000000 / CLK_NS);
  localparam int unsigned PROG_LIMIT_CYC =
    32'(BYTE_PROGRAM_TIME_US * 1000 / CLK_NS);

  typedef enum logic [2:0] {
    op_read, op_program, op_chip_erase, op_lockout,
    op_id_entry, op_id_exit, op_id_exit_short
  } pfcs_op_type;

  typedef struct packed {
    pfcs_op_type op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pfcs_cmd_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } pfcs_pins_type;
endpackage : pfcs_pkg

// *** rtl/pfcs_bus_cycle.sv ***
`timescale 1ns/10ps
module pfcs_bus_cycle (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic wr,
  input wire logic [pfcs_pkg::ADDR_W-1:0] addr,
  input wire logic [pfcs_pkg::DATA_W-1:0] wdata,
  input wire logic [pfcs_pkg::DATA_W-1:0] dq_in,
  output pfcs_pkg::pfcs_pins_type pins,
  output logic done,
  output logic [pfcs_pkg::DATA_W-1:0] rdata
);
  typedef enum logic [1:0] {
    st_idle, st_setup, st_strobe, st_recover
  } pfcs_bus_state_type;

  pfcs_bus_state_type state_r;
  pfcs_pkg::pfcs_pins_type pins_r;
  logic [7:0] cnt_r;
  logic wr_r;
  logic done_r;
  logic [pfcs_pkg::DATA_W-1:0] rdata_r;
  logic [pfcs_pkg::DATA_W-1:0] dq_meta_r;
  logic [pfcs_pkg::DATA_W-1:0] dq_sync_r;

  wire cnt_zero = (cnt_r == 8'h00);
  wire [7:0] strobe_len = wr_r ? 8'(pfcs_pkg::WE_LOW_CYC - 1)
    : 8'(pfcs_pkg::ACCESS_CYC + pfcs_pkg::SYNC_CYC - 1);

  assign pins = pins_r;
  assign done = done_r;
  assign rdata = rdata_r;

  always_ff @(posedge core_clk) begin
    dq_meta_r <= dq_in;
    dq_sync_r <= dq_meta_r;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= st_idle;
      pins_r <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  dq_out: '0, dq_oe: 1'b0};
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        st_idle: begin
          if (start) begin
            pins_r.addr <= addr;
            pins_r.ce_n <= 1'b0;
            pins_r.dq_out <= wdata;
            pins_r.dq_oe <= wr;
            wr_r <= wr;
            state_r <= st_setup;
          end
        end
        st_setup: begin
          // oe stays high for the whole write, we stays high for reads
          pins_r.we_n <= ~wr_r;
          pins_r.oe_n <= wr_r;
          cnt_r <= strobe_len;
          state_r <= st_strobe;
        end
        st_strobe: begin
          if (cnt_zero) begin
            pins_r.we_n <= 1'b1;
            pins_r.oe_n <= 1'b1;
            pins_r.ce_n <= 1'b1;
            if (!wr_r) begin
              rdata_r <= dq_sync_r;
            end
            cnt_r <= 8'(pfcs_pkg::FLOAT_CYC - 1);
            state_r <= st_recover;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        st_recover: begin
          // data held past the rising strobe edge, then released
          if (cnt_zero) begin
            pins_r.dq_oe <= 1'b0;
            done_r <= 1'b1;
            state_r <= st_idle;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end
endmodule : pfcs_bus_cycle

// *** rtl/pfcs_sequencer.sv ***
// Function
// - chip erase is six writes ending 5555h/10h.
// - byte program is three unlock writes then target address and data.
// - lockout is six writes ending 5555h/40h.
// - id mode entered by three writes ending 5555h/90h.
// - id mode left by three writes ending F0h or one F0h write.
// - true data after program; host waits for completion first.
`timescale 1ns/10ps
module pfcs_sequencer #(
  parameter int unsigned ERASE_TIMEOUT_CYC = pfcs_pkg::ERASE_LIMIT_CYC,
  parameter int unsigned PROG_TIMEOUT_CYC = pfcs_pkg::PROG_LIMIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input pfcs_pkg::pfcs_cmd_type cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [pfcs_pkg::DATA_W-1:0] rsp_data,
  output logic rsp_error,
  output pfcs_pkg::pfcs_pins_type flash_pins,
  input wire logic [pfcs_pkg::DATA_W-1:0] flash_dq_in
);
  typedef enum logic [2:0] {
    m_idle, m_issue, m_wait, m_poll_issue, m_poll_wait
  } pfcs_main_state_type;

  pfcs_main_state_type state_r;
  pfcs_pkg::pfcs_cmd_type cmd_r;
  logic [2:0] idx_r;
  logic bus_start_r;
  logic cmd_ready_r;
  logic rsp_valid_r;
  logic rsp_error_r;
  logic [pfcs_pkg::DATA_W-1:0] rsp_data_r;
  logic [pfcs_pkg::DATA_W-1:0] prev_r;
  logic have_prev_r;
  logic [31:0] timer_r;
  logic bus_done;
  logic [pfcs_pkg::DATA_W-1:0] bus_rdata;

  // step table decode
  wire is_read = (cmd_r.op == pfcs_pkg::op_read);
  wire is_prog = (cmd_r.op == pfcs_pkg::op_program);
  wire is_six = (cmd_r.op == pfcs_pkg::op_chip_erase) ||
    (cmd_r.op == pfcs_pkg::op_lockout);
  wire is_single = is_read || (cmd_r.op == pfcs_pkg::op_id_exit_short);
  wire needs_poll = is_prog || is_six;
  wire [2:0] step_count = is_single ? pfcs_pkg::STEPS_ONE
    : is_prog ? pfcs_pkg::STEPS_PROGRAM
    : is_six ? pfcs_pkg::STEPS_SIX
    : pfcs_pkg::STEPS_THREE;
  wire last_step = (idx_r == step_count - 3'h1);

  logic [pfcs_pkg::DATA_W-1:0] third_code;
  always_comb begin
    case (cmd_r.op)
      pfcs_pkg::op_program: third_code = pfcs_pkg::CODE_PROGRAM;
      pfcs_pkg::op_chip_erase: third_code = pfcs_pkg::CODE_SETUP;
      pfcs_pkg::op_lockout: third_code = pfcs_pkg::CODE_SETUP;
      pfcs_pkg::op_id_entry: third_code = pfcs_pkg::CODE_ID_ENTRY;
      default: third_code = pfcs_pkg::CODE_ID_EXIT;
    endcase
  end

  wire [pfcs_pkg::DATA_W-1:0] final_code =
    (cmd_r.op == pfcs_pkg::op_lockout) ? pfcs_pkg::CODE_LOCKOUT
    : pfcs_pkg::CODE_ERASE;

  logic [pfcs_pkg::ADDR_W-1:0] step_addr;
  logic [pfcs_pkg::DATA_W-1:0] step_data;
  always_comb begin
    step_addr = pfcs_pkg::UNLOCK_ADDR_A;
    step_data = pfcs_pkg::UNLOCK_DATA_A;
    if (is_single) begin
      // any address takes the one-write id exit
      step_addr = cmd_r.addr;
      step_data = pfcs_pkg::CODE_ID_EXIT;
    end else begin
      case (idx_r)
        3'h1, 3'h4: begin
          step_addr = pfcs_pkg::UNLOCK_ADDR_B;
          step_data = pfcs_pkg::UNLOCK_DATA_B;
        end
        3'h2: step_data = third_code;
        3'h3: begin
          if (is_prog) begin
            step_addr = cmd_r.addr;
            step_data = cmd_r.data;
          end
        end
        3'h5: step_data = final_code;
        default: step_data = pfcs_pkg::UNLOCK_DATA_A;
      endcase
    end
  end

  // completion test on two successive reads
  wire alt_stopped = have_prev_r &&
    (prev_r[pfcs_pkg::ALT_BIT] == bus_rdata[pfcs_pkg::ALT_BIT]);
  wire poll_true = !is_prog ||
    (bus_rdata[pfcs_pkg::POLL_BIT] == cmd_r.data[pfcs_pkg::POLL_BIT]);
  wire op_complete = alt_stopped && poll_true;
  // lockout is polled with the erase limit
  wire [31:0] timer_limit = is_prog ? PROG_TIMEOUT_CYC : ERASE_TIMEOUT_CYC;
  wire timed_out = (timer_r >= timer_limit);
  // the bus cycle samples wr and addr with the start pulse, which is
  // registered: it stands while the main machine is already in m_wait
  wire bus_step = (state_r == m_wait);
  wire bus_wr = bus_step && !is_read;
  // poll reads always go to the target address of the command
  wire [pfcs_pkg::ADDR_W-1:0] bus_addr = bus_step ? step_addr : cmd_r.addr;
  wire cmd_take = cmd_valid && cmd_ready_r;

  pfcs_bus_cycle u_bus (
    .core_clk(core_clk),
    .rst(rst),
    .start(bus_start_r),
    .wr(bus_wr),
    .addr(bus_addr),
    .wdata(step_data),
    .dq_in(flash_dq_in),
    .pins(flash_pins),
    .done(bus_done),
    .rdata(bus_rdata)
  );

  assign cmd_ready = cmd_ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign rsp_error = rsp_error_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= m_idle;
      cmd_r <= '{op: pfcs_pkg::op_read, addr: '0, data: '0};
      idx_r <= 3'h0;
      bus_start_r <= 1'b0;
      cmd_ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_error_r <= 1'b0;
      rsp_data_r <= '0;
      prev_r <= '0;
      have_prev_r <= 1'b0;
      timer_r <= 32'h0000_0000;
    end else begin
      bus_start_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      case (state_r)
        m_idle: begin
          // ready is registered, so it drops one cycle after the take
          cmd_ready_r <= 1'b1;
          if (cmd_take) begin
            cmd_r <= cmd;
            idx_r <= 3'h0;
            cmd_ready_r <= 1'b0;
            state_r <= m_issue;
          end
        end
        m_issue: begin
          bus_start_r <= 1'b1;
          state_r <= m_wait;
        end
        m_wait: begin
          if (bus_done && !last_step) begin
            idx_r <= idx_r + 3'h1;
            state_r <= m_issue;
          end else if (bus_done && needs_poll) begin
            // last write landed: first poll read goes out at once
            have_prev_r <= 1'b0;
            timer_r <= 32'h0000_0000;
            bus_start_r <= 1'b1;
            state_r <= m_poll_wait;
          end else if (bus_done) begin
            rsp_valid_r <= 1'b1;
            rsp_error_r <= 1'b0;
            rsp_data_r <= is_read ? bus_rdata : step_data;
            state_r <= m_idle;
          end
        end
        m_poll_issue: begin
          bus_start_r <= 1'b1;
          state_r <= m_poll_wait;
        end
        m_poll_wait: begin
          // timer only runs while a poll read is out
          timer_r <= timer_r + 32'h0000_0001;
          if (bus_done && (op_complete || timed_out)) begin
            rsp_valid_r <= 1'b1;
            rsp_error_r <= !op_complete;
            rsp_data_r <= bus_rdata;
            state_r <= m_idle;
          end else if (bus_done) begin
            // kept to compare its toggle bit with the next read
            prev_r <= bus_rdata;
            have_prev_r <= 1'b1;
            state_r <= m_poll_issue;
          end
        end
        default: state_r <= m_idle;
      endcase
    end
  end
endmodule : pfcs_sequencer

// *** verification/pfcs_sequencer_chk.sv ***
`timescale 1ns/10ps
module pfcs_sequencer_chk #(
  parameter int unsigned ERASE_TIMEOUT_CYC = 1,
  parameter int unsigned PROG_TIMEOUT_CYC = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input pfcs_pkg::pfcs_cmd_type cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [pfcs_pkg::DATA_W-1:0] rsp_data,
  input wire logic rsp_error,
  input pfcs_pkg::pfcs_pins_type flash_pins,
  input wire logic [pfcs_pkg::DATA_W-1:0] flash_dq_in
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire we = !flash_pins.we_n;
  wire rd = !flash_pins.oe_n;
  AST_RST_IDLE: assert property (disable iff (1'b0)
    rst |=> flash_pins.we_n && flash_pins.ce_n && !cmd_ready && !rsp_valid)
    else $error("pins or handshake active after reset");
  AST_WR_GATE: assert property (we |-> !flash_pins.ce_n && !rd)
    else $error("write strobe without chip select or with output gate");
  AST_NO_FIGHT: assert property (rd |-> !flash_pins.dq_oe && !we)
    else $error("data driven during a read");
  AST_WE_WIDTH: assert property ($fell(flash_pins.we_n) |-> we[*5] ##1 !we)
    else $error("write strobe width wrong");
  AST_WR_SETUP: assert property ($fell(flash_pins.we_n) |->
    $past(!flash_pins.ce_n && flash_pins.dq_oe))
    else $error("write strobe fell before select and data");
  AST_WR_HOLD: assert property (we && $past(we) |->
    $stable(flash_pins.addr) && $stable(flash_pins.dq_out))
    else $error("address or data moved under write strobe");
  AST_DQ_HOLD: assert property ($rose(flash_pins.we_n) |->
    (flash_pins.dq_oe && $stable(flash_pins.dq_out))[*8])
    else $error("data released too early after write");
  AST_TAKE: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stayed high after take");
  AST_RSP_RDY: assert property (rsp_valid |-> !cmd_ready ##1 cmd_ready)
    else $error("ready not restored after response");
  cover property (cmd_valid && cmd_ready && cmd.op == pfcs_pkg::op_program);
  cover property (cmd_valid && cmd_ready && cmd.op == pfcs_pkg::op_chip_erase);
  cover property (rsp_valid && rsp_error);
endmodule : pfcs_sequencer_chk

// *** verification/pfcs_flash_model.sv ***
`timescale 1ns/10ps
module pfcs_flash_model #(
  parameter int BUSY_CYC = 100,
  parameter logic [7:0] MAKER = 8'h5A, // arbitrary value
  parameter logic [7:0] PART = 8'hC3 // arbitrary value
) (
  input wire logic core_clk,
  input wire logic hang,
  input pfcs_pkg::pfcs_pins_type pins,
  output logic [7:0] dq
);
  logic [7:0] mem [int];
  logic [16:0] la;
  logic [7:0] ld = 8'h00;
  logic lock = 0, idm = 0, tog = 0, ok = 0;
  int st = 0, busy = 0;
  realtime tf;
  initial dq = 8'h00;
  function automatic logic [7:0] rd(logic [16:0] a);
    if (idm && a < 3) return a == 0 ? MAKER : a == 1 ? PART : {7'h00, lock};
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd
  task automatic wr(logic [16:0] a, logic [7:0] d);
    logic u5, u2, boot;
    u5 = a == 17'h0_5555;
    u2 = a == 17'h0_2AAA;
    boot = lock && a < 17'h0_2000;
    if (st == 7) begin
      if (!boot) mem[a] = rd(a) & d;
      if (!boot) ld = d;
      if (!boot) busy = BUSY_CYC;
      st = 0;
    end else if (d == 8'hF0 && (st == 0 || st == 2 && u5)) begin
      idm = 0;
      st = 0;
    end else if ((st == 0 || st == 3) && u5 && d == 8'hAA) st++;
    else if ((st == 1 || st == 4) && u2 && d == 8'h55) st++;
    else if (st == 2 && u5 && d == 8'hA0) st = 7;
    else if (st == 2 && u5 && d == 8'h80) st = 3;
    else if (st == 2 && u5 && d == 8'h90) begin
      idm = 1;
      st = 0;
    end else if (st == 5 && u5 && d == 8'h10) begin
      foreach (mem[k]) if (!(lock && k < 17'h0_2000)) mem[k] = 8'hFF;
      busy = BUSY_CYC;
      st = 0;
    end else if (st == 5 && u5 && d == 8'h40) begin
      lock = 1;
      st = 0;
    end else st = 0;
  endtask : wr
  always @(negedge pins.we_n) begin
    la = pins.addr;
    ok = !pins.ce_n && pins.oe_n;
    tf = $realtime;
  end
  always @(posedge pins.we_n)
    if (ok && $realtime - tf >= 15 && busy == 0) wr(la, pins.dq_out);
  always @(posedge core_clk) if (busy > 0 && !hang) busy--;
  always @(negedge pins.oe_n) if (busy > 0) tog = ~tog;
  always @(posedge core_clk)
    if (!pins.ce_n && !pins.oe_n && pins.we_n)
      dq <= busy > 0 ? {~ld[7], tog, ld[5:0]} : rd(pins.addr);
    else dq <= ~dq;
endmodule : pfcs_flash_model

// *** verification/tb_pfcs_sequencer.sv ***
`timescale 1ns/10ps
module tb_pfcs_sequencer;
  localparam int unsigned ECYC = 2000;
  localparam int unsigned PCYC = 1000;
  localparam int BUSY = 100;
  localparam logic [7:0] MK = 8'h5A;
  localparam logic [7:0] PT = 8'hC3;
  logic core_clk = 0, rst = 1, cmd_valid = 0, hang = 0, lk = 0, idm = 0;
  pfcs_pkg::pfcs_cmd_type cmd = '0;
  logic cmd_ready, rsp_valid, rsp_error;
  logic [7:0] rsp_data, dq, d;
  logic [16:0] a;
  logic [8:0] got, ex;
  pfcs_pkg::pfcs_pins_type pins;
  int failures = 0, tests_run = 0, cyc = 0, seed = 32'h0000_6069;
  logic [7:0] em [int];
  pfcs_sequencer #(.ERASE_TIMEOUT_CYC(ECYC), .PROG_TIMEOUT_CYC(PCYC)) DUT (
    .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .flash_pins(pins), .flash_dq_in(dq)
  );
  pfcs_flash_model #(.BUSY_CYC(BUSY), .MAKER(MK), .PART(PT)) u_flash (
    .core_clk(core_clk), .hang(hang), .pins(pins), .dq(dq)
  );
  initial forever #2 core_clk = ~core_clk;
  function automatic logic [7:0] mv(logic [16:0] x);
    return em.exists(x) ? em[x] : 8'hFF;
  endfunction : mv
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic check(logic [8:0] seen, logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic run(pfcs_pkg::pfcs_op_type op, logic [16:0] x, logic [7:0] v);
    int n;
    if (op == pfcs_pkg::op_program && !(lk && x < 17'h0_2000)) em[x] = mv(x) & v;
    if (op == pfcs_pkg::op_chip_erase)
      foreach (em[k]) if (!(lk && k < 17'h0_2000)) em[k] = 8'hFF;
    if (op == pfcs_pkg::op_lockout) lk = 1;
    if (op == pfcs_pkg::op_id_entry) idm = 1;
    if (op >= pfcs_pkg::op_id_exit) idm = 0;
    ex = {1'b0, mv(x)};
    if (op == pfcs_pkg::op_program) ex[8] = ex[7] != v[7];
    if (op == pfcs_pkg::op_read && idm && x < 3)
      ex = {1'b0, x == 0 ? MK : x == 1 ? PT : {7'h00, lk}};
    if (op >= pfcs_pkg::op_id_entry)
      ex = {1'b0, op == pfcs_pkg::op_id_entry ? 8'h90 : 8'hF0};
    @(posedge core_clk);
    #1;
    cmd_valid = 1;
    cmd = '{op, x, v};
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 100) failures++;
    @(posedge core_clk);
    #1 cmd_valid = 0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 5000);
    if (n >= 5000) failures++;
    got = {rsp_error, rsp_data};
  endtask : run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    #1 rst = 0;
    for (int i = 0; i < 8; i++) begin
      a = {4'h1, 13'($random(seed))};
      d = 8'($random(seed));
      run(pfcs_pkg::op_read, a, d); check(got, ex);
      run(pfcs_pkg::op_program, a, d); check(got, ex);
      run(pfcs_pkg::op_program, a, ~d ^ 8'($random(seed))); check(got, ex);
      run(pfcs_pkg::op_read, a, d); check(got, ex);
    end
    $display("test random program done");
    run(pfcs_pkg::op_program, 17'h0_0100, 8'h3C); check(got, ex);
    for (int k = 0; k < 2; k++) begin
      run(pfcs_pkg::op_id_entry, a, d); check(got, ex);
      for (int j = 0; j < 3; j++) begin
        run(pfcs_pkg::op_read, 17'(j), d); check(got, ex);
      end
      run(k ? pfcs_pkg::op_id_exit_short : pfcs_pkg::op_id_exit, a, d);
      check(got, ex);
      run(pfcs_pkg::op_lockout, a, d); check(got, ex);
    end
    run(pfcs_pkg::op_program, 17'h0_0100, 8'h00); check(got, ex);
    $display("test ident and lockout done");
    run(pfcs_pkg::op_chip_erase, a, d); check(got, ex);
    run(pfcs_pkg::op_read, 17'h0_0100, d); check(got, ex);
    run(pfcs_pkg::op_read, a, d); check(got, ex);
    $display("test chip erase done");
    hang = 1;
    run(pfcs_pkg::op_program, a, 8'h00); check({8'h00, got[8]}, 9'h001);
    hang = 0;
    repeat (BUSY + 2) @(posedge core_clk);
    run(pfcs_pkg::op_read, a, d); check(got, ex);
    $display("test poll timeout done");
    give_verdict();
  end
endmodule : tb_pfcs_sequencer
bind pfcs_sequencer pfcs_sequencer_chk #(
  .ERASE_TIMEOUT_CYC(ERASE_TIMEOUT_CYC),
  .PROG_TIMEOUT_CYC(PROG_TIMEOUT_CYC)
) u_chk (
  .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .rsp_error(rsp_error), .flash_pins(flash_pins), .flash_dq_in(flash_dq_in)
);
